// >>> rtl/rsf_top.v
// resonance suppression stage: two notches and a low-pass in cascade, auto search control
// assumes a classic Wishbone master, samples synchronous to clk_i, an external resonance estimator
`timescale 1ns/100ps
`include "rsf_map.vh"
module rsf_top #(
  parameter [39:0] STABLE_CYC = `RSF_STABLE_CYC,
  parameter [15:0] LP_RST     = `RSF_LP_RST
) (
  // clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // command samples in
  input  wire        sample_valid_i,
  input  wire [15:0] sample_i,
  output wire        sample_ready_o,
  // filtered samples out
  output wire        out_valid_o,
  output wire [15:0] out_data_o,
  input  wire        out_ready_i,
  // resonance estimator
  input  wire        est_valid_i,
  input  wire [15:0] est_freq_i,
  input  wire [15:0] est_depth_i,
  input  wire        quiet_i,
  // search state
  output reg         auto_active_o
);

  // settings
  reg [15:0] lp_time_q;
  reg [15:0] n2_freq_q;
  reg [15:0] n2_depth_q;
  reg [15:0] n3_freq_q;
  reg [15:0] n3_depth_q;
  reg [1:0]  mode_q;
  // search state
  reg        done_q;
  reg        slot_q;
  reg [39:0] stable_cnt_q;
  // filter state
  reg [15:0] s2_q;
  reg [15:0] s3_q;
  reg [15:0] lp_q;

  wire        req;
  wire        wr;
  wire        take;
  wire [15:0] cur;
  wire [15:0] wv;
  reg  [15:0] n2_out;
  reg  [15:0] n3_out;
  reg  [15:0] lp_out;
  reg  [15:0] est_dep_c;

  function [15:0] lane_merge;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      lane_merge = {(s[1] ? d[15:8] : old[15:8]), (s[0] ? d[7:0] : old[7:0])};
    end
  endfunction

  function in_rng;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_rng = (v >= lo) && (v <= hi);
    end
  endfunction

  function is_adr;
    input [31:0] a;
    input [15:0] idx;
    begin
      is_adr = (a == {14'h0, idx, 2'h0});
    end
  endfunction

  function [3:0] msb_pos;
    input [15:0] v;
    integer i;
    begin
      msb_pos = 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        if (v[i])
          msb_pos = i[3:0];
      end
    end
  endfunction

  // one-pole section: s moves toward x by (x - s) / 2^k
  function [15:0] lp_step;
    input [15:0] s;
    input [15:0] x;
    input [3:0]  k;
    reg signed [16:0] diff;
    reg signed [16:0] sh;
    begin
      diff    = $signed({x[15], x}) - $signed({s[15], s});
      sh      = diff >>> k;
      lp_step = s + sh[15:0];
    end
  endfunction

  // notch: remove depth/32 of the part of x above the tracked corner
  function [15:0] notch_out;
    input [15:0] x;
    input [15:0] s;
    input [15:0] dep;
    reg signed [16:0] hp;
    reg signed [23:0] prod;
    begin
      hp        = $signed({x[15], x}) - $signed({s[15], s});
      prod      = hp * $signed({1'b0, dep[5:0]});
      notch_out = x - prod[`RSF_DEPTH_SHIFT+15:`RSF_DEPTH_SHIFT];
    end
  endfunction

  function [3:0] notch_k;
    input [15:0] f;
    begin
      notch_k = `RSF_NOTCH_KREF - msb_pos(f);
    end
  endfunction

  // longer time constant, slower section; large settings saturate the shift
  function [3:0] lp_k;
    input [15:0] t;
    begin
      if (msb_pos(t) >= (`RSF_LP_KMAX - 4'h1))
        lp_k = `RSF_LP_KMAX;
      else
        lp_k = msb_pos(t) + 4'h1;
    end
  endfunction

  // ack comes one cycle after the request; a write lands on the edge that ends the ack cycle
  assign req  = wb_cyc_i & wb_stb_i;
  assign wr   = req & wb_we_i & wb_ack_o;
  assign take = sample_valid_i & sample_ready_o;

  assign cur = is_adr(wb_adr_i, `RSF_IDX_LP_TIME)   ? lp_time_q :
               is_adr(wb_adr_i, `RSF_IDX_N2_FREQ)   ? n2_freq_q :
               is_adr(wb_adr_i, `RSF_IDX_N2_DEPTH)  ? n2_depth_q :
               is_adr(wb_adr_i, `RSF_IDX_N3_FREQ)   ? n3_freq_q :
               is_adr(wb_adr_i, `RSF_IDX_N3_DEPTH)  ? n3_depth_q :
               is_adr(wb_adr_i, `RSF_IDX_AUTO_MODE) ? {14'h0, mode_q} : 16'h0000;
  assign wv  = lane_merge(cur, wb_dat_i, wb_sel_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        if (is_adr(wb_adr_i, `RSF_IDX_STATUS))
          wb_dat_o <= {29'h0, slot_q, done_q, auto_active_o};
        else
          wb_dat_o <= {16'h0000, cur};
      end
    end
  end

  // filter cascade on the incoming sample
  always @* begin
    if (n2_depth_q == `RSF_DEPTH_MIN)
      n2_out = sample_i;
    else
      n2_out = notch_out(sample_i, s2_q, n2_depth_q);
    if (n3_depth_q == `RSF_DEPTH_MIN)
      n3_out = n2_out;
    else
      n3_out = notch_out(n2_out, s3_q, n3_depth_q);
    if (lp_time_q == `RSF_LP_MIN)
      lp_out = n3_out;
    else
      lp_out = lp_step(lp_q, n3_out, lp_k(lp_time_q));
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      s2_q <= 16'h0000;
      s3_q <= 16'h0000;
      lp_q <= 16'h0000;
    end else if (ce_i && take) begin
      s2_q <= lp_step(s2_q, sample_i, notch_k(n2_freq_q));
      s3_q <= lp_step(s3_q, n2_out, notch_k(n3_freq_q));
      lp_q <= lp_out;
    end
  end

  always @* begin
    if (est_depth_i > `RSF_DEPTH_MAX)
      est_dep_c = `RSF_DEPTH_MAX;
    else
      est_dep_c = est_depth_i;
  end

  // settings and auto search; a software write wins over the search in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      lp_time_q     <= LP_RST;
      n2_freq_q     <= `RSF_FREQ_RST;
      n2_depth_q    <= `RSF_DEPTH_RST;
      n3_freq_q     <= `RSF_FREQ_RST;
      n3_depth_q    <= `RSF_DEPTH_RST;
      mode_q        <= `RSF_MODE_RST;
      done_q        <= 1'b0;
      slot_q        <= 1'b0;
      stable_cnt_q  <= 40'h0000000000;
      auto_active_o <= 1'b0;
    end else if (ce_i) begin
      auto_active_o <= (mode_q != `RSF_MODE_OFF);
      if (wr && is_adr(wb_adr_i, `RSF_IDX_AUTO_MODE)) begin
        if (in_rng(wv, `RSF_DEPTH_MIN, `RSF_MODE_MAX)) begin
          mode_q <= wv[1:0];
          if (wv[1:0] == `RSF_MODE_ONCE ||
              (wv[1:0] == `RSF_MODE_CONT && mode_q == `RSF_MODE_OFF)) begin
            n2_freq_q    <= `RSF_FREQ_RST;
            n2_depth_q   <= `RSF_DEPTH_RST;
            n3_freq_q    <= `RSF_FREQ_RST;
            n3_depth_q   <= `RSF_DEPTH_RST;
            done_q       <= 1'b0;
            slot_q       <= 1'b0;
            stable_cnt_q <= 40'h0000000000;
          end
          // going to 0 keeps settings 1 or 2 to 2 keeps everything running
        end
      end else if (wr) begin
        if (is_adr(wb_adr_i, `RSF_IDX_LP_TIME) && in_rng(wv, `RSF_LP_MIN, `RSF_LP_MAX))
          lp_time_q <= wv;
        else if (is_adr(wb_adr_i, `RSF_IDX_N2_FREQ) && in_rng(wv, `RSF_FREQ_MIN, `RSF_FREQ_MAX))
          n2_freq_q <= wv;
        else if (is_adr(wb_adr_i, `RSF_IDX_N2_DEPTH) && in_rng(wv, `RSF_DEPTH_MIN, `RSF_DEPTH_MAX))
          n2_depth_q <= wv;
        else if (is_adr(wb_adr_i, `RSF_IDX_N3_FREQ) && in_rng(wv, `RSF_FREQ_MIN, `RSF_FREQ_MAX))
          n3_freq_q <= wv;
        else if (is_adr(wb_adr_i, `RSF_IDX_N3_DEPTH) && in_rng(wv, `RSF_DEPTH_MIN, `RSF_DEPTH_MAX))
          n3_depth_q <= wv;
      end else if (mode_q != `RSF_MODE_OFF) begin
        // estimates fill the two notches in turn
        if (est_valid_i && in_rng(est_freq_i, `RSF_FREQ_MIN, `RSF_FREQ_MAX)) begin
          if (!slot_q) begin
            n2_freq_q  <= est_freq_i;
            n2_depth_q <= est_dep_c;
          end else begin
            n3_freq_q  <= est_freq_i;
            n3_depth_q <= est_dep_c;
          end
          slot_q       <= ~slot_q;
          done_q       <= 1'b1;
          stable_cnt_q <= 40'h0000000000;
        end else if (mode_q == `RSF_MODE_ONCE && done_q) begin
          if (!quiet_i)
            stable_cnt_q <= 40'h0000000000;
          else if (stable_cnt_q >= STABLE_CYC - 40'h0000000001) begin
            mode_q       <= `RSF_MODE_OFF;
            stable_cnt_q <= 40'h0000000000;
          end else
            stable_cnt_q <= stable_cnt_q + 40'h0000000001;
        end
        // mode 2 has no exit of its own and keeps taking estimates
      end
    end
  end

  rsf_buf #(
    .W (16)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (sample_valid_i),
    .in_data_i   (lp_out),
    .in_ready_o  (sample_ready_o),
    .out_valid_o (out_valid_o),
    .out_data_o  (out_data_o),
    .out_ready_i (out_ready_i)
  );

endmodule // rsf_top

// >>> rtl/rsf_map.vh
// register map, reset values, ranges and timing of the resonance suppression filters
// assumes a 20 MHz clock and a classic Wishbone slave with byte address = 4 * register index
// How it works
// - third-notch frequency: 16 bits, hertz, 50..2000 accepted, resets to 1000.
// - third notch passes samples unchanged whenever its depth is zero.
// - third-notch depth: 16 bits, decibels, 0..32 accepted, resets to 0, zero disables.
// - second notch passes samples unchanged whenever its depth is zero.
// - low-pass time: 16 bits, 0.1 ms units, 0..1000, zero bypasses the low-pass.
// - auto modes 1 and 2 search and write found frequency and depth into notches.
// - mode 1 returns itself to 0 after suppression and 20 stable minutes.
// - mode 2 searches continuously and never clears itself.
// - mode changes 0-1, 0-2, 1-1, 2-1 clear both notch settings, then enable search.
// - mode changes 1-0, 2-0 keep the notch settings and stop searching.
// - mode changes 1-2, 2-2 keep settings and searching goes on uninterrupted.
// - second-notch frequency: 16 bits, hertz, 50..2000 accepted, resets to 1000.
// - second-notch depth: 16 bits, decibels, 0..32 accepted, resets to 0.
`ifndef RSF_MAP_VH
`define RSF_MAP_VH

// register indices; byte address is four times the index
`define RSF_IDX_LP_TIME   16'h0232
`define RSF_IDX_N2_FREQ   16'h0256
`define RSF_IDX_N2_DEPTH  16'h0258
`define RSF_IDX_N3_FREQ   16'h025A
`define RSF_IDX_N3_DEPTH  16'h025C
`define RSF_IDX_AUTO_MODE 16'h025E
`define RSF_IDX_STATUS    16'h0260

// reset values
`define RSF_FREQ_RST      16'h03E8
`define RSF_DEPTH_RST     16'h0000
`define RSF_LP_RST        16'h0002
`define RSF_MODE_RST      2'h0

// accepted ranges
`define RSF_FREQ_MIN      16'h0032
`define RSF_FREQ_MAX      16'h07D0
`define RSF_DEPTH_MIN     16'h0000
`define RSF_DEPTH_MAX     16'h0020
`define RSF_LP_MIN        16'h0000
`define RSF_LP_MAX        16'h03E8
`define RSF_MODE_MAX      16'h0002

// auto modes
`define RSF_MODE_OFF      2'h0
`define RSF_MODE_ONCE     2'h1
`define RSF_MODE_CONT     2'h2

// status bits
`define RSF_ST_ACTIVE     0
`define RSF_ST_DONE       1
`define RSF_ST_SLOT       2

// filter shaping
`define RSF_NOTCH_KREF    4'hB
`define RSF_LP_KMAX       4'hF
`define RSF_DEPTH_SHIFT   5

// stable time before mode 1 ends: minutes, and cycles derived at the clock rate
`define RSF_STABLE_MIN    40'h14
`define RSF_SEC_PER_MIN   40'h3C
`define RSF_CLK_HZ        40'h1312D00
`define RSF_STABLE_CYC    (`RSF_STABLE_MIN * `RSF_SEC_PER_MIN * `RSF_CLK_HZ)

`endif

// >>> rtl/rsf_buf.v
// two-entry skid buffer between the filter result and the receiver
// assumes one clock; head entry is the registered output
`timescale 1ns/100ps
module rsf_buf #(
  parameter W = 16
) (
  // clock, reset, enable
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  // filling side
  input  wire         in_valid_i,
  input  wire [W-1:0] in_data_i,
  output reg          in_ready_o,
  // draining side
  output reg          out_valid_o,
  output reg  [W-1:0] out_data_o,
  input  wire         out_ready_i
);

  reg         spare_v_q;
  reg [W-1:0] spare_q;
  wire        push;
  wire        pop;

  // ready is a flop kept as the inverse of the spare flag: no path from out_ready_i reaches the sender
  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      spare_v_q   <= 1'b0;
      in_ready_o  <= 1'b1;
      spare_q     <= {W{1'b0}};
      out_valid_o <= 1'b0;
      out_data_o  <= {W{1'b0}};
    end else if (ce_i) begin
      if (spare_v_q) begin
        if (pop) begin
          out_data_o <= spare_q;
          spare_v_q  <= 1'b0;
          in_ready_o <= 1'b1;
        end
      end else if (!out_valid_o || pop) begin
        out_data_o  <= in_data_i;
        out_valid_o <= push;
      end else if (push) begin
        spare_q   <= in_data_i;
        spare_v_q <= 1'b1;
        in_ready_o <= 1'b0;
      end
    end
  end

endmodule // rsf_buf

// >>> verif/rsf_top_props.sv
// port-level assertions for rsf_top: bus handshake, sample buffer, search flag
// assumes rsf_map.vh on the include path and ce_i high whenever a request is made
`timescale 1ns/100ps
`include "rsf_map.vh"
module rsf_top_props (
  // clock, reset, enable
  input logic        clk_i,
  input logic        rst_i,
  input logic        ce_i,
  // wishbone slave
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [31:0] wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  // sample stream
  input logic        sample_valid_i,
  input logic [15:0] sample_i,
  input logic        sample_ready_o,
  input logic        out_valid_o,
  input logic [15:0] out_data_o,
  input logic        out_ready_i,
  // estimator and search state
  input logic        est_valid_i,
  input logic [15:0] est_freq_i,
  input logic [15:0] est_depth_i,
  input logic        quiet_i,
  input logic        auto_active_o
);
  localparam logic [31:0] MODE_ADR = {14'h0000, `RSF_IDX_AUTO_MODE, 2'h0};
  logic mode_wr;
  assign mode_wr = ce_i && wb_ack_o && wb_we_i && wb_adr_i == MODE_ADR && wb_sel_i[1:0] == 2'h3;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_NEXT: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  AST_ACK_CAUSE: assert property (ce_i && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("acknowledge without request");
  AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_OUT_HOLD: assert property (
    ce_i && out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("stalled output word changed");
  AST_OUT_NEXT: assert property (
    ce_i && sample_valid_i && sample_ready_o && !out_valid_o |=> out_valid_o)
    else $error("taken sample not presented next cycle");
  AST_FULL_ONLY: assert property (!sample_ready_o |-> out_valid_o)
    else $error("input refused while output empty");
  AST_MODE_ON: assert property (
    mode_wr && wb_dat_i[15:0] inside {16'h0001, 16'h0002} |-> ##2 auto_active_o)
    else $error("search flag not raised after mode write");
  AST_MODE_OFF: assert property (mode_wr && wb_dat_i[15:0] == 16'h0000 |-> ##2 !auto_active_o)
    else $error("search flag not dropped after mode write");
  AST_RST_OUT: assert property (
    disable iff (1'b0) ce_i && rst_i |=> !wb_ack_o && !out_valid_o && sample_ready_o)
    else $error("outputs not cleared by reset");
  AST_CE_HOLD: assert property (
    !ce_i |=> $stable(wb_ack_o) && $stable(out_valid_o) && $stable(out_data_o) && $stable(auto_active_o))
    else $error("state moved while clock enable low");
endmodule // rsf_top_props

bind rsf_top rsf_top_props rsf_top_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sample_valid_i(sample_valid_i), .sample_i(sample_i), .sample_ready_o(sample_ready_o),
  .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i), .est_valid_i(est_valid_i),
  .est_freq_i(est_freq_i), .est_depth_i(est_depth_i), .quiet_i(quiet_i), .auto_active_o(auto_active_o)
);

// >>> verif/testbench.sv
// self-checking bench for rsf_top: register map, auto mode control, sample stream
// assumes rsf_map.vh on the include path; reads and samples are checked by one monitor
`timescale 1ns/100ps
`include "rsf_map.vh"
module testbench;
  localparam logic [15:0] MD = `RSF_IDX_AUTO_MODE;
  localparam logic [15:0] F2 = `RSF_IDX_N2_FREQ;
  localparam logic [15:0] D2 = `RSF_IDX_N2_DEPTH;
  localparam logic [15:0] F3 = `RSF_IDX_N3_FREQ;
  localparam logic [15:0] D3 = `RSF_IDX_N3_DEPTH;
  localparam logic [15:0] LP = `RSF_IDX_LP_TIME;
  localparam logic [15:0] ST = `RSF_IDX_STATUS;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0000_0000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sample_valid_i = 1'b0;
  logic [15:0] sample_i = 16'h0000;
  logic        sample_ready_o;
  logic        out_valid_o;
  logic [15:0] out_data_o;
  logic        out_ready_i = 1'b0;
  logic        est_valid_i = 1'b0;
  logic [15:0] est_freq_i = 16'h0000;
  logic [15:0] est_depth_i = 16'h0000;
  logic        quiet_i = 1'b0;
  logic        auto_active_o;
  logic [31:0] rq[$];
  logic [15:0] sq[$];
  logic [47:0] rng[13];
  int          n_fail = 0;
  int          num_checks = 0;
  int          seed = 33522;
  logic        sdone = 1'b0;

  // the stable count is cut to 20 cycles so the self-exit fits in the run
  rsf_top #(.STABLE_CYC(40'h14), .LP_RST(`RSF_LP_RST)) rsf_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i), .sample_ready_o(sample_ready_o),
    .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i), .est_valid_i(est_valid_i),
    .est_freq_i(est_freq_i), .est_depth_i(est_depth_i), .quiet_i(quiet_i), .auto_active_o(auto_active_o)
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // classic single cycle; the master holds everything until ack is sampled
  task automatic bus(input logic we, input logic [15:0] idx, input logic [15:0] v);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {14'h0000, idx, 2'h0};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {16'h0000, v};
    // no cycle count is assumed: only the watchdog ends a wait that never sees ack
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
    rq.push_back({16'h0000, exp});
    bus(1'b0, idx, 16'h0000);
  endtask

  task automatic notes(input logic [15:0] f2, input logic [15:0] d2, input logic [15:0] f3, input logic [15:0] d3);
    rd(F2, f2);
    rd(D2, d2);
    rd(F3, f3);
    rd(D3, d3);
  endtask

  task automatic est(input logic [15:0] f, input logic [15:0] d);
    est_valid_i <= 1'b1;
    est_freq_i <= f;
    est_depth_i <= d;
    @(posedge clk_i);
    est_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk(wb_dat_o, rq.pop_front());
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
      chk({16'h0000, out_data_o}, {16'h0000, sq.pop_front()});
  end

  initial begin
    #(50 * 20000);
    n_fail++;
    finish_test();
  end

  initial begin
    rng = '{{F3, 16'h0031, 16'h03E8}, {F3, 16'h0032, 16'h0032}, {F3, 16'h07D1, 16'h0032},
            {F3, 16'h07D0, 16'h07D0}, {D3, 16'h0021, 16'h0000}, {D3, 16'h0020, 16'h0020},
            {F2, 16'h0031, 16'h03E8}, {F2, 16'h07D0, 16'h07D0}, {D2, 16'h0021, 16'h0000},
            {D2, 16'h0020, 16'h0020}, {LP, 16'h03E9, `RSF_LP_RST}, {LP, 16'h03E8, 16'h03E8},
            {MD, 16'h0003, 16'h0000}};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    notes(16'h03E8, 16'h0000, 16'h03E8, 16'h0000);
    rd(LP, `RSF_LP_RST);
    rd(MD, 16'h0000);
    bus(1'b1, 16'h0040, 16'hFFFF);
    rd(16'h0040, 16'h0000);
    foreach (rng[i]) begin
      bus(1'b1, rng[i][47:32], rng[i][31:16]);
      rd(rng[i][47:32], rng[i][15:0]);
    end
    bus(1'b1, MD, 16'h0001);
    notes(16'h03E8, 16'h0000, 16'h03E8, 16'h0000);
    est(16'h012C, 16'h000A);
    est(16'h0258, 16'h0014);
    notes(16'h012C, 16'h000A, 16'h0258, 16'h0014);
    rd(ST, 16'h0003);
    bus(1'b1, MD, 16'h0002);
    bus(1'b1, MD, 16'h0002);
    notes(16'h012C, 16'h000A, 16'h0258, 16'h0014);
    quiet_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    rd(MD, 16'h0002);
    quiet_i <= 1'b0;
    bus(1'b1, MD, 16'h0000);
    est(16'h0190, 16'h0005);
    notes(16'h012C, 16'h000A, 16'h0258, 16'h0014);
    bus(1'b1, MD, 16'h0002);
    notes(16'h03E8, 16'h0000, 16'h03E8, 16'h0000);
    // with the clock enable low the estimate is lost and the slot stays on notch2
    ce_i <= 1'b0;
    est(16'h0123, 16'h0004);
    ce_i <= 1'b1;
    est(16'h0190, 16'h0005);
    rd(F2, 16'h0190);
    bus(1'b1, MD, 16'h0001);
    notes(16'h03E8, 16'h0000, 16'h03E8, 16'h0000);
    est(16'h02BC, 16'h0003);
    bus(1'b1, MD, 16'h0001);
    notes(16'h03E8, 16'h0000, 16'h03E8, 16'h0000);
    est(16'h02BC, 16'h0003);
    repeat (40) @(posedge clk_i);
    rd(MD, 16'h0001);
    // the read after 19 quiet edges is taken on the 20th, just before the mode drops
    quiet_i <= 1'b1;
    repeat (19) @(posedge clk_i);
    rd(MD, 16'h0001);
    rd(MD, 16'h0000);
    rd(ST, 16'h0006);
    quiet_i <= 1'b0;
    bus(1'b1, MD, 16'h0001);
    est(16'h02BC, 16'h0030);
    bus(1'b1, MD, 16'h0000);
    notes(16'h02BC, 16'h0020, 16'h03E8, 16'h0000);
    // depth at its ceiling: the operator reruns the search, which starts from cleared notches
    bus(1'b1, MD, 16'h0001);
    notes(16'h03E8, 16'h0000, 16'h03E8, 16'h0000);
    est(16'h0190, 16'h0005);
    rd(F2, 16'h0190);
    // a second reset in mid-run restores every setting and stops the search
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    notes(16'h03E8, 16'h0000, 16'h03E8, 16'h0000);
    rd(LP, `RSF_LP_RST);
    rd(MD, 16'h0000);
    bus(1'b1, LP, 16'h0000);
    bus(1'b1, D2, 16'h0000);
    bus(1'b1, D3, 16'h0000);
    // all stages bypassed, so every word must come out unchanged and in order
    fork
      begin
        repeat (200) begin
          sample_valid_i <= 1'b1;
          sample_i <= 16'($random(seed));
          do @(posedge clk_i); while (sample_ready_o !== 1'b1);
          sq.push_back(sample_i);
        end
        sample_valid_i <= 1'b0;
        sdone = 1'b1;
      end
      begin
        repeat (6) @(posedge clk_i);
        while (!sdone) begin
          out_ready_i <= 1'($random(seed));
          @(posedge clk_i);
        end
      end
    join
    out_ready_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(32'(sq.size()), 32'h0000_0000);
    finish_test();
  end
endmodule // testbench
